// file: rtl/uedb_pkg.sv
// Package for the USB endpoint descriptor bank engine.
// Assumes the descriptors sit in RAM reached by a word-wide master port.
package uedb_pkg;

    localparam logic [31:0] UEDB_EP_STRIDE   = 32'h0000_0020;
    localparam logic [31:0] UEDB_BANK_STRIDE = 32'h0000_0010;
    localparam logic [31:0] UEDB_OFF_PTR     = 32'h0000_0000;
    localparam logic [31:0] UEDB_OFF_SIZE    = 32'h0000_0004;
    localparam logic [31:0] UEDB_OFF_EXT     = 32'h0000_0008;
    localparam logic [31:0] UEDB_OFF_STAT    = 32'h0000_000A;
    localparam logic [31:0] UEDB_WORD_MASK   = 32'hFFFF_FFFC;
    localparam logic [3:0]  UEDB_BE_ALL      = 4'hF;
    localparam logic [3:0]  UEDB_BE_EXT      = 4'h3;
    localparam logic [3:0]  UEDB_BE_STAT     = 4'h4;
    localparam int          UEDB_ZLP_BIT     = 31;
    localparam int          UEDB_SIZE_HI     = 30;
    localparam int          UEDB_SIZE_LO     = 28;
    localparam int          UEDB_MULTI_HI    = 27;
    localparam int          UEDB_MULTI_LO    = 14;
    localparam int          UEDB_TALLY_HI    = 13;
    localparam int          UEDB_TALLY_LO    = 0;
    localparam int          UEDB_FLOW_BIT    = 17;
    localparam int          UEDB_CRC_BIT     = 16;
    localparam int          UEDB_LINK_HI     = 3;
    localparam int          UEDB_BESL_HI     = 7;
    localparam int          UEDB_BESL_LO     = 4;
    localparam int          UEDB_WAKE_BIT    = 8;

    typedef enum logic [1:0] {
        UEDB_OUT, UEDB_IN, UEDB_SETUP, UEDB_LPM
    } uedb_dir_e;

    typedef struct packed {
        logic [2:0] ep;
        logic       bank;
        uedb_dir_e  dir;
        logic       iso;
    } uedb_txn_s;

    typedef struct packed {
        logic        ack;
        logic [10:0] payload;
        logic [3:0]  subtype;
    } uedb_lpm_s;

    typedef struct packed {
        logic nak;
        logic overrun;
        logic crc_err;
    } uedb_end_s;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0]  be;
    } uedb_mem_s;

    // Maximum packet size in bytes for a three-bit size code.
    function automatic logic [13:0] uedb_max_packet(input logic [2:0] code);
        case (code)
            3'h0:    return 14'h0008;
            3'h1:    return 14'h0010;
            3'h2:    return 14'h0020;
            3'h3:    return 14'h0040;
            3'h4:    return 14'h0080;
            3'h5:    return 14'h0100;
            3'h6:    return 14'h0200;
            default: return 14'h03FF;
        endcase
    endfunction : uedb_max_packet

endpackage : uedb_pkg

// file: rtl/uedb_bank_engine.sv
// Descriptor bank engine: reads a bank, moves payload, writes results back.
// Assumes the packet engine and RAM run on clk; RAM answers with mem_ack.
`timescale 1ns/10ps
module uedb_bank_engine (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic [31:0]        desc_base,
    input  wire logic               txn_start,
    input  wire uedb_pkg::uedb_txn_s txn_in,
    input  wire uedb_pkg::uedb_lpm_s lpm_in,
    output      logic               txn_busy,
    output      logic               txn_done,
    output      logic               zlp_hw,
    output      uedb_pkg::uedb_mem_s mem,
    input  wire logic               mem_ack,
    input  wire logic [31:0]        mem_rdata,
    output      logic               tx_valid,
    input  wire logic               tx_ready,
    output      logic [7:0]         tx_data,
    input  wire logic               rx_valid,
    output      logic               rx_ready,
    input  wire logic [7:0]         rx_data,
    input  wire logic               rx_end,
    input  wire uedb_pkg::uedb_end_s rx_status,
    output      logic [3:0]         lpm_link_state,
    output      logic [3:0]         lpm_besl,
    output      logic               lpm_remote_wake
);
    import uedb_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE, S_RD_PTR, S_RD_SIZE, S_IN_FETCH, S_IN_SEND, S_OUT_RECV,
        S_OUT_STORE, S_WB_SIZE, S_WB_EXT, S_WB_STAT, S_DONE
    } uedb_state_e;

    uedb_state_e state;
    uedb_state_e next_state;
    uedb_txn_s   txn;
    uedb_lpm_s   lpm;
    uedb_end_s   fin;
    logic [31:0] desc;
    logic [31:0] ptr;
    logic [31:0] size_word;
    logic [13:0] limit;
    logic [13:0] count;
    logic [13:0] woff;
    logic [2:0]  nfill;
    logic [31:0] word_buf;
    logic        ended;
    logic        overrun;
    logic [13:0] rd_max;
    logic [13:0] rd_tally;
    logic        is_in;
    logic        byte_in;
    logic [13:0] next_total;
    logic [7:0]  stat_byte;
    logic [15:0] token;

    assign is_in    = (txn.dir == UEDB_IN);
    assign rd_max   = uedb_max_packet(mem_rdata[UEDB_SIZE_HI:UEDB_SIZE_LO]);
    assign rd_tally = mem_rdata[UEDB_TALLY_HI:UEDB_TALLY_LO];
    assign byte_in  = (state == S_OUT_RECV) && rx_valid && !rx_end;
    assign rx_ready = (state == S_OUT_RECV);
    assign tx_valid = (state == S_IN_SEND);
    assign tx_data  = word_buf[7:0];
    assign txn_busy = (state != S_IDLE);
    assign txn_done = (state == S_DONE);
    assign next_total = size_word[UEDB_MULTI_HI:UEDB_MULTI_LO] + count;
    assign token    = {1'b0, lpm.payload, lpm.subtype};
    assign lpm_link_state  = lpm.payload[UEDB_LINK_HI:0];
    assign lpm_besl        = lpm.payload[UEDB_BESL_HI:UEDB_BESL_LO];
    assign lpm_remote_wake = lpm.payload[UEDB_WAKE_BIT];

    // Flow error means NAK outside isochronous, overrun inside it.
    always_comb begin
        stat_byte    = 8'h00;
        stat_byte[1] = txn.iso ? (overrun | fin.overrun) : fin.nak;
        stat_byte[0] = txn.iso & fin.crc_err;
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (txn_start) begin
                    if (txn_in.dir == UEDB_LPM) begin
                        next_state = lpm_in.ack ? S_WB_EXT : S_DONE;
                    end else begin
                        next_state = S_RD_PTR;
                    end
                end
            end
            S_RD_PTR: begin
                if (mem_ack) begin
                    next_state = S_RD_SIZE;
                end
            end
            S_RD_SIZE: begin
                if (mem_ack && !is_in) begin
                    next_state = S_OUT_RECV;
                end else if (mem_ack) begin
                    next_state = (rd_tally == 14'h0000) ? S_WB_SIZE
                                                        : S_IN_FETCH;
                end
            end
            S_IN_FETCH: begin
                if (mem_ack) begin
                    next_state = S_IN_SEND;
                end
            end
            S_IN_SEND: begin
                if (tx_ready && (count + 14'h0001 == limit)) begin
                    next_state = S_WB_SIZE;
                end else if (tx_ready && nfill == 3'h1) begin
                    next_state = S_IN_FETCH;
                end
            end
            S_OUT_RECV: begin
                if (rx_end) begin
                    next_state = (nfill != 3'h0) ? S_OUT_STORE : S_WB_SIZE;
                end else if (byte_in && count < limit && nfill == 3'h3) begin
                    next_state = S_OUT_STORE;
                end
            end
            S_OUT_STORE: begin
                if (mem_ack) begin
                    next_state = ended ? S_WB_SIZE : S_OUT_RECV;
                end
            end
            S_WB_SIZE: begin
                if (mem_ack) begin
                    next_state = is_in ? S_DONE : S_WB_STAT;
                end
            end
            S_WB_EXT, S_WB_STAT: begin
                if (mem_ack) begin
                    next_state = S_DONE;
                end
            end
            S_DONE: begin
                next_state = S_IDLE;
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Descriptor capture.
    always_ff @(posedge clk) begin
        if (reset) begin
            txn       <= '0;
            lpm       <= '0;
            desc      <= 32'h0000_0000;
            ptr       <= 32'h0000_0000;
            size_word <= 32'h0000_0000;
            limit     <= 14'h0000;
            zlp_hw    <= 1'b0;
        end else begin
            if (state == S_IDLE && txn_start) begin
                txn  <= txn_in;
                desc <= desc_base + (32'(txn_in.ep) * UEDB_EP_STRIDE)
                        + (32'(txn_in.bank) * UEDB_BANK_STRIDE);
                if (txn_in.dir == UEDB_LPM && lpm_in.ack) begin
                    lpm <= lpm_in;
                end
            end
            if (state == S_RD_PTR && mem_ack) begin
                ptr <= mem_rdata & UEDB_WORD_MASK;
            end
            if (state == S_RD_SIZE && mem_ack) begin
                size_word <= mem_rdata;
                zlp_hw    <= is_in & mem_rdata[UEDB_ZLP_BIT];
                if (is_in && rd_tally < rd_max) begin
                    limit <= rd_tally;
                end else begin
                    limit <= rd_max;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Payload path: bytes shift through one word buffer.
    always_ff @(posedge clk) begin
        if (reset) begin
            count    <= 14'h0000;
            woff     <= 14'h0000;
            nfill    <= 3'h0;
            word_buf <= 32'h0000_0000;
            ended    <= 1'b0;
            overrun  <= 1'b0;
            fin      <= '0;
        end else begin
            case (state)
                S_IDLE: begin
                    count   <= 14'h0000;
                    woff    <= 14'h0000;
                    nfill   <= 3'h0;
                    ended   <= 1'b0;
                    overrun <= 1'b0;
                    fin     <= '0;
                end
                S_IN_FETCH: begin
                    if (mem_ack) begin
                        word_buf <= mem_rdata;
                        nfill    <= 3'h4;
                        woff     <= woff + 14'h0004;
                    end
                end
                S_IN_SEND: begin
                    if (tx_ready) begin
                        word_buf <= {8'h00, word_buf[31:8]};
                        nfill    <= nfill - 3'h1;
                        count    <= count + 14'h0001;
                    end
                end
                S_OUT_RECV: begin
                    if (rx_end) begin
                        ended <= 1'b1;
                        fin   <= rx_status;
                        word_buf <= word_buf >> (6'(3'h4 - nfill) * 6'h08);
                    end else if (byte_in && count < limit) begin
                        word_buf <= {rx_data, word_buf[31:8]};
                        nfill    <= nfill + 3'h1;
                        count    <= count + 14'h0001;
                    end else if (byte_in) begin
                        overrun  <= 1'b1;
                    end
                end
                S_OUT_STORE: begin
                    if (mem_ack) begin
                        nfill <= 3'h0;
                        woff  <= woff + 14'h0004;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RAM master requests, held until acknowledged.
    always_comb begin
        mem = '0;
        case (state)
            S_RD_PTR: begin
                mem.req  = 1'b1;
                mem.addr = desc + UEDB_OFF_PTR;
            end
            S_RD_SIZE: begin
                mem.req  = 1'b1;
                mem.addr = desc + UEDB_OFF_SIZE;
            end
            S_IN_FETCH: begin
                mem.req  = 1'b1;
                mem.addr = ptr + 32'(woff);
            end
            S_OUT_STORE: begin
                mem.req   = 1'b1;
                mem.we    = 1'b1;
                mem.addr  = ptr + 32'(woff);
                mem.wdata = word_buf;
                mem.be    = UEDB_BE_ALL >> (3'h4 - nfill);
            end
            S_WB_SIZE: begin
                mem.req   = 1'b1;
                mem.we    = 1'b1;
                mem.addr  = desc + UEDB_OFF_SIZE;
                mem.be    = UEDB_BE_ALL;
                mem.wdata = size_word;
                if (is_in) begin
                    mem.wdata[UEDB_MULTI_HI:UEDB_MULTI_LO] = next_total;
                end else begin
                    mem.wdata[UEDB_TALLY_HI:UEDB_TALLY_LO] = count;
                end
            end
            S_WB_EXT: begin
                mem.req   = 1'b1;
                mem.we    = 1'b1;
                mem.addr  = desc + UEDB_OFF_EXT;
                mem.be    = UEDB_BE_EXT;
                mem.wdata = {16'h0000, token};
            end
            S_WB_STAT: begin
                mem.req   = 1'b1;
                mem.we    = 1'b1;
                mem.addr  = (desc + UEDB_OFF_STAT) & UEDB_WORD_MASK;
                mem.be    = UEDB_BE_STAT;
                mem.wdata = {8'h00, stat_byte, 16'h0000};
            end
            default: begin
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_size_read;
        state == S_RD_SIZE && mem_ack;
    endsequence

    sequence s_start_data;
        state == S_IDLE && txn_start && txn_in.dir != UEDB_LPM;
    endsequence

    chk_bank_offset: assert property (
        s_start_data |=> mem.addr == $past(desc_base) +
            32'($past(txn_in.ep)) * UEDB_EP_STRIDE +
            32'($past(txn_in.bank)) * UEDB_BANK_STRIDE)
        else $error("descriptor bank address wrong");
    chk_zlp_mode: assert property (
        s_size_read |=> zlp_hw == ($past(mem_rdata[31]) && is_in))
        else $error("auto zero length mode not taken");
    chk_size_limit: assert property (
        s_size_read |=> limit <= uedb_max_packet($past(mem_rdata[30:28])))
        else $error("limit beyond max packet size");
    chk_in_tally: assert property (
        state == S_IN_SEND |-> count < limit)
        else $error("IN sent more than the tally");
    chk_in_total: assert property (
        state == S_WB_SIZE && is_in |-> mem.wdata[27:14] ==
            size_word[27:14] + count)
        else $error("IN running total wrong");
    chk_out_tally: assert property (
        state == S_WB_SIZE && !is_in |-> mem.wdata[13:0] == count)
        else $error("received count not written back");
    chk_token_ack: assert property (
        state == S_WB_EXT |-> lpm.ack && mem.wdata[15:0] == token)
        else $error("token written without ACK");
    chk_flow_nak: assert property (
        state == S_WB_STAT && !txn.iso |-> mem.wdata[17] == fin.nak)
        else $error("flow error does not follow NAK");
    chk_crc_flag: assert property (
        state == S_WB_STAT |-> mem.wdata[16] == (txn.iso && fin.crc_err))
        else $error("CRC flag wrong");
    chk_in_no_stat: assert property (
        state == S_WB_SIZE && is_in && mem_ack |=> state == S_DONE)
        else $error("IN touched the bank status");
    chk_ram_hold: assert property (
        mem.req && !mem_ack |=> mem.req && $stable(mem.addr))
        else $error("RAM request dropped before ack");

endmodule : uedb_bank_engine

// file: bench/uedb_ram_model.sv
// RAM model answering the engine's master port, fast or with two waits.
// Assumes each request stands unchanged until its acknowledge edge.
`timescale 1ns/10ps
module uedb_ram_model (
    input  wire logic                clk,
    input  wire logic                slow,
    input  wire uedb_pkg::uedb_mem_s mem,
    output      logic                mem_ack,
    output      logic [31:0]         mem_rdata
);
    import uedb_pkg::*;
    logic [31:0] m [0:63];
    logic [1:0]  waits;
    logic [5:0]  idx;
    assign idx = mem.addr[7:2];
    initial begin
        for (int i = 0; i < 64; i++) begin
            m[i] = 32'h0000_0000;
        end
        mem_ack = 1'b0;
        mem_rdata = 32'h0000_0000;
        waits = 2'h0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Read data is inverted between answers so a stale value never matches.
    always @(posedge clk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem.req === 1'b1 && mem_ack !== 1'b1) begin
            if (waits < (slow ? 2'h2 : 2'h0)) begin
                waits <= waits + 2'h1;
            end else begin
                waits <= 2'h0;
                mem_ack <= 1'b1;
                if (mem.we) begin
                    for (int k = 0; k < 4; k++) begin
                        if (mem.be[k]) begin
                            m[idx][8*k +: 8] <= mem.wdata[8*k +: 8];
                        end
                    end
                end else begin
                    mem_rdata <= m[idx];
                end
            end
        end
    end
endmodule : uedb_ram_model

// file: bench/uedb_bank_engine_bench.sv
// Testbench for the descriptor bank engine: IN, OUT, SETUP and LPM runs.
// Assumes the RAM model stands on the engine's master port.
`timescale 1ns/10ps
module uedb_bank_engine_bench;
    import uedb_pkg::*;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        txn_start = 1'b0;
    uedb_txn_s   txn_in = '0;
    uedb_lpm_s   lpm_in = '0;
    logic        tx_ready = 1'b1;
    logic        rx_valid = 1'b0;
    logic [7:0]  rx_data = 8'h00;
    logic        rx_end = 1'b0;
    uedb_end_s   rx_status = '0;
    logic        slow = 1'b0;
    logic        stall = 1'b0;
    logic        txn_busy, txn_done, zlp_hw, mem_ack, tx_valid, rx_ready;
    logic [31:0] mem_rdata;
    logic [7:0]  tx_data;
    logic [3:0]  lpm_link_state, lpm_besl;
    logic        lpm_remote_wake;
    uedb_mem_s   mem;
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          tx_cnt = 0;
    int          lim;
    uedb_dir_e   o_dir [5] = '{UEDB_SETUP, UEDB_OUT, UEDB_OUT, UEDB_OUT,
                              UEDB_OUT};
    logic        o_iso [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    int          o_n   [5] = '{3, 5, 0, 9, 2};
    uedb_end_s   o_st  [5] = '{3'h0, 3'h1, 3'h4, 3'h0, 3'h2};
    logic [13:0] o_tal [5] = '{14'h0003, 14'h0005, 14'h0000, 14'h0008,
                              14'h0002};
    logic [7:0]  o_stat [5] = '{8'h00, 8'h01, 8'h02, 8'h02, 8'h02};

    // The descriptor table sits above zero so that a dropped base shows.
    uedb_bank_engine DUT (.clk(clk), .reset(reset),
        .desc_base(32'h0000_0040), .txn_start(txn_start), .txn_in(txn_in),
        .lpm_in(lpm_in), .txn_busy(txn_busy), .txn_done(txn_done),
        .zlp_hw(zlp_hw), .mem(mem), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_data(rx_data), .rx_end(rx_end), .rx_status(rx_status),
        .lpm_link_state(lpm_link_state), .lpm_besl(lpm_besl),
        .lpm_remote_wake(lpm_remote_wake));
    uedb_ram_model RAM (.clk(clk), .slow(slow), .mem(mem),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [7:0] ram_byte(input logic [31:0] a);
        return RAM.m[a[7:2]][8*a[1:0] +: 8];
    endfunction : ram_byte

    // Sends n bytes for OUT and SETUP, then waits for the done pulse.
    task automatic run(input uedb_txn_s t, input uedb_lpm_s l,
                       input int n, input uedb_end_s st);
        int k;
        @(negedge clk);
        txn_in = t;
        lpm_in = l;
        txn_start = 1'b1;
        @(negedge clk);
        txn_start = 1'b0;
        chk(txn_busy, 1'b1);
        if (t.dir == UEDB_OUT || t.dir == UEDB_SETUP) begin
            for (int i = 0; i <= n; i++) begin
                rx_valid = (i < n);
                rx_end = (i == n);
                rx_status = st;
                rx_data = 8'h11 + i[7:0];
                while (rx_ready !== 1'b1) @(negedge clk);
                @(negedge clk);
            end
            rx_valid = 1'b0;
            rx_end = 1'b0;
        end
        for (k = 0; k < 5000 && txn_done !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        chk(txn_done, 1'b1);
        @(negedge clk);
    endtask : run

    ////////////////////////////////////////////////////////////////////////
    always #2 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_mismatch++;
            $display("[FAIL] %0t timeout", $time);
            end_sim();
        end
    end

    // Sink of IN bytes, stalling on even cycles while stall is set.
    always @(negedge clk) begin
        tx_ready = stall ? cycles[0] : 1'b1;
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            chk(tx_data, ram_byte(32'h0000_0080 + tx_cnt));
            tx_cnt++;
        end
    end

    initial begin
        repeat (16) @(negedge clk);
        reset = 1'b0;
        chk({txn_busy, txn_done, tx_valid, rx_ready, mem.req, zlp_hw,
             lpm_link_state, lpm_besl, lpm_remote_wake}, 32'h0000_0000);
        // Distinct bytes in the IN buffer catch a wrong lane order.
        for (int w = 32; w < 64; w++) begin
            RAM.m[w] = {4{8'(w)}} ^ 32'h00C0_4080;
        end
        for (int c = 0; c < 8; c++) begin
            lim = (c == 7) ? 600 : (8 << c);
            RAM.m[28] = 32'h0000_0080;
            RAM.m[29] = {c[0], c[2:0], 14'(c * 3), 14'h0258};
            RAM.m[30] = 32'hC3FF_1234;
            slow = c[0];
            stall = c[0];
            tx_cnt = 0;
            run(uedb_txn_s'{3'h1, 1'b1, UEDB_IN, c[2]}, '0, 0, '0);
            chk(tx_cnt, lim);
            chk(RAM.m[29], {c[0], c[2:0], 14'(c * 3 + lim), 14'h0258});
            chk(zlp_hw, c[0]);
            chk(RAM.m[30], 32'hC3FF_1234);
            $display("test in size code %0d done", c);
        end
        for (int j = 0; j < 5; j++) begin
            RAM.m[36] = 32'h0000_00C0;
            RAM.m[37] = {4'h0, 14'h0040, 14'h3FFF};
            RAM.m[38] = 32'hC3FF_1234;
            slow = j[0];
            for (int w = 48; w < 51; w++) begin
                RAM.m[w] = 32'hAAAA_AAAA;
            end
            run(uedb_txn_s'{3'h2, 1'b1, o_dir[j], o_iso[j]}, '0, o_n[j],
                o_st[j]);
            for (int b = 0; b < 12; b++) begin
                chk(ram_byte(32'h0000_00C0 + b),
                    (b < o_tal[j]) ? 32'h11 + b : 32'hAA);
            end
            chk(RAM.m[37], {4'h0, 14'h0040, o_tal[j]});
            chk(RAM.m[38], {8'hC3, o_stat[j], 16'h1234});
            chk(RAM.m[38][17:16], o_stat[j][1:0]);
            chk(zlp_hw, 1'b0);
            $display("test receive case %0d done", j);
        end
        RAM.m[18] = 32'h5500_0000;
        run(uedb_txn_s'{3'h0, 1'b0, UEDB_LPM, 1'b0},
            uedb_lpm_s'{1'b1, 11'h5A3, 4'h3}, 0, '0);
        chk({lpm_link_state, lpm_besl, lpm_remote_wake}, 9'h075);
        run(uedb_txn_s'{3'h0, 1'b0, UEDB_LPM, 1'b0},
            uedb_lpm_s'{1'b0, 11'h0FF, 4'h9}, 0, '0);
        chk(RAM.m[18], 32'h5500_5A33);
        chk({lpm_link_state, lpm_besl, lpm_remote_wake}, 9'h075);
        $display("test token capture done");
        end_sim();
    end
endmodule : uedb_bank_engine_bench
